/* inc/vec_pkg.sv */
// vec_pkg: register map, field layout and timing constants of the
// video encoder clock-mask / caption / attribute block.
// assumes a 32-bit Avalon-MM slave port with byte addresses.
//
// Function
// - four aux pattern registers hold 16 bits, shifted one bit per encoder cycle
// - horizontal mask window starts 13-bit count of encoder cycles after hsync
// - aux horizontal mask start counts encoder cycles from hsync start
// - horizontal mask window width is a 13-bit encoder cycle count
// - vertical mask window starts 13-bit line count after vsync
// - vertical mask window height is a 13-bit line count
// - unrefreshed field caption data is replaced by the 7-bit fallback character
// - caption field select: 0 off, 1 odd, 2 even, 3 both
// - odd field sends bits 14-8 first, then bits 6-0
// - even field sends bits 14-8 first, then bits 6-0
// - device adds the parity bit to every caption character
// - attribute byte 0: NTSC word0 B in 5-3, A in 2-0; PAL ignores
// - attribute byte 1: word2/group2 in 7-4, word1/group1 in 3-0
// - NTSC attribute byte 2: CRC in 5-0, insert enable in bit 7
// - PAL attribute byte 2: group4 in 5-3, group3 in 2-0, enable bit 7
// - attribute data inserted only while insert enable bit is one
// - status bit 9 even caption flag, bit 8 odd caption flag
// - status bit 4 field id, bit 1 balance, bit 0 full monitor
// - mask control on gates output clock to window; off passes it unmasked
// - internal mode: aux patterns and aux start form internal clock pattern

package vec_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_AUX_PTN_0 = 7'h00;
    localparam logic [6:0] OFS_AUX_PTN_1 = 7'h04;
    localparam logic [6:0] OFS_AUX_PTN_2 = 7'h08;
    localparam logic [6:0] OFS_AUX_PTN_3 = 7'h0C;
    localparam logic [6:0] OFS_HORIZ_MASK_START = 7'h10;
    localparam logic [6:0] OFS_HORIZ_AUX_MASK_START = 7'h14;
    localparam logic [6:0] OFS_HORIZ_MASK_RANGE = 7'h18;
    localparam logic [6:0] OFS_VERT_MASK_START = 7'h1C;
    localparam logic [6:0] OFS_VERT_MASK_RANGE = 7'h20;
    localparam logic [6:0] OFS_CAPTION_CONTROL = 7'h24;
    localparam logic [6:0] OFS_CAPTION_ODD = 7'h28;
    localparam logic [6:0] OFS_CAPTION_EVEN = 7'h2C;
    localparam logic [6:0] OFS_ATTR_0 = 7'h30;
    localparam logic [6:0] OFS_ATTR_1 = 7'h34;
    localparam logic [6:0] OFS_ATTR_2 = 7'h38;
    localparam logic [6:0] OFS_VIDEO_STATUS = 7'h3C;
    localparam logic [6:0] OFS_CLOCK_CONTROL = 7'h40;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_INT_MODE = 15;
    localparam int POS_MASK_EN = 10;
    localparam int POS_PAL_MODE = 0;
    localparam int POS_CHAR_HI = 8;
    localparam int POS_ATTR_EN = 7;
    localparam int POS_EVEN_FLAG = 9;
    localparam int POS_ODD_FLAG = 8;
    localparam int POS_FIELD_ID = 4;
    localparam int POS_BALANCE = 1;
    localparam int POS_FULL = 0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PATTERN = 16'h0000;
    localparam logic [12:0] RST_COUNT = 13'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [12:0] COUNT_MAX = 13'h1FFF;
    localparam logic [12:0] CAPTION_LINE = 13'h0015;
    localparam logic [12:0] ATTR_LINE = 13'h0014;

endpackage

/* logic/vec_encoder.sv */
// vec_encoder: pixel clock mask windows, aux pattern clock, caption and
// attribute insertion, status word, behind an Avalon-MM slave.
// assumes encoder clock, syncs, field id and display monitors arrive
// asynchronously and are sampled by clock.
`timescale 1ns/1ps
`default_nettype none

module vec_encoder
    import vec_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // video timing pins
    input wire logic encoder_clock,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic field_id,
    input wire logic microdisplay_balance,
    input wire logic microdisplay_full,
    // pixel clock outputs
    output logic pixel_clock_out,
    output logic internal_pixel_clock,
    output logic aux_window_active,
    // caption output
    output logic caption_valid,
    output logic caption_even_field,
    output logic [7:0] caption_first_char,
    output logic [7:0] caption_second_char,
    // attribute output
    output logic attribute_valid,
    output logic attribute_pal,
    output logic [19:0] attribute_word
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] enc_sync;
        logic [2:0] hs_sync;
        logic [2:0] vs_sync;
        logic [1:0] fid_sync;
        logic [1:0] bal_sync;
        logic [1:0] full_sync;
        logic [63:0] aux_clock_pattern_bits;
        logic [12:0] horiz_window_start;
        logic [12:0] horiz_aux_start;
        logic [12:0] horiz_window_range;
        logic [12:0] vert_window_start;
        logic [12:0] vert_window_range;
        logic clock_mask_enable;
        logic internal_clock_pattern_mode;
        logic pal_mode;
        logic [6:0] caption_fallback_char;
        logic [1:0] caption_field_select;
        logic [13:0] odd_chars;
        logic [13:0] even_chars;
        logic [7:0] attr0;
        logic [7:0] attr1;
        logic [7:0] attr2;
        logic odd_fresh;
        logic even_fresh;
        logic odd_caption_flag;
        logic even_caption_flag;
        logic [12:0] hcount;
        logic [12:0] lcount;
        logic [5:0] ptn_ptr;
        logic ptn_run;
        logic pix_out;
        logic int_clk;
        logic aux_win;
        logic cap_valid;
        logic cap_even;
        logic [7:0] cap_c0;
        logic [7:0] cap_c1;
        logic atr_valid;
        logic [19:0] atr_word;
        logic ack;
        logic [31:0] rdata;
    } vec_state_t;

    vec_state_t st;
    vec_state_t next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] vec_merge16(input logic [15:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    function automatic logic [7:0] vec_parity(input logic [6:0] ch);
        return {~(^ch), ch};
    endfunction

    function automatic logic vec_in_range(input logic [12:0] pos,
                                          input logic [12:0] start,
                                          input logic [12:0] range);
        logic [13:0] stop;
        stop = {1'b0, start} + {1'b0, range};
        return (pos >= start) && ({1'b0, pos} < stop);
    endfunction

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    logic enc_tick;
    logic hs_rise;
    logic vs_rise;
    logic req;
    logic wr_fire;
    logic rd_take;
    logic in_window;
    logic cap_slot;
    logic cap_send;
    logic cur_even;
    logic [15:0] wmerged;

    always_comb
    begin
        next_st = st;
        enc_tick = st.enc_sync[1] & ~st.enc_sync[2];
        hs_rise = st.hs_sync[1] & ~st.hs_sync[2];
        vs_rise = st.vs_sync[1] & ~st.vs_sync[2];
        req = read | write;
        wr_fire = write & st.ack;
        rd_take = read & ~st.ack;
        cur_even = st.fid_sync[1];
        wmerged = 16'h0000;

        // synchronisers
        next_st.enc_sync = {st.enc_sync[1:0], encoder_clock};
        next_st.hs_sync = {st.hs_sync[1:0], hsync};
        next_st.vs_sync = {st.vs_sync[1:0], vsync};
        next_st.fid_sync = {st.fid_sync[0], field_id};
        next_st.bal_sync = {st.bal_sync[0], microdisplay_balance};
        next_st.full_sync = {st.full_sync[0], microdisplay_full};

        // position counters
        if (hs_rise)
        begin
            next_st.hcount = RST_COUNT;
        end
        else if (enc_tick && st.hcount != COUNT_MAX)
        begin
            next_st.hcount = st.hcount + 13'h0001;
        end
        if (vs_rise)
        begin
            next_st.lcount = RST_COUNT;
        end
        else if (hs_rise && st.lcount != COUNT_MAX)
        begin
            next_st.lcount = st.lcount + 13'h0001;
        end

        // mask windows
        in_window = vec_in_range(st.hcount, st.horiz_window_start,
                                 st.horiz_window_range)
                    && vec_in_range(st.lcount, st.vert_window_start,
                                    st.vert_window_range);
        next_st.aux_win = vec_in_range(st.hcount, st.horiz_aux_start,
                                       st.horiz_window_range)
                          && vec_in_range(st.lcount, st.vert_window_start,
                                          st.vert_window_range);
        next_st.pix_out = st.enc_sync[2] & (~st.clock_mask_enable | in_window);

        // aux pattern shifter
        if (hs_rise)
        begin
            next_st.ptn_run = 1'b0;
            next_st.ptn_ptr = 6'h00;
        end
        else if (enc_tick)
        begin
            if (st.ptn_run)
            begin
                next_st.ptn_ptr = st.ptn_ptr + 6'h01;
            end
            else if (st.hcount == st.horiz_aux_start)
            begin
                next_st.ptn_run = 1'b1;
            end
        end
        if (st.internal_clock_pattern_mode)
        begin
            next_st.int_clk = st.ptn_run & st.aux_clock_pattern_bits[st.ptn_ptr];
        end
        else
        begin
            next_st.int_clk = st.enc_sync[2];
        end

        // caption slot
        cap_slot = hs_rise && (st.lcount == CAPTION_LINE);
        cap_send = cap_slot && (cur_even ? st.caption_field_select[1]
                                         : st.caption_field_select[0]);
        next_st.cap_valid = cap_send;
        if (cap_send)
        begin
            next_st.cap_even = cur_even;
            if (cur_even)
            begin
                if (st.even_fresh)
                begin
                    next_st.cap_c0 = vec_parity(st.even_chars[13:7]);
                    next_st.cap_c1 = vec_parity(st.even_chars[6:0]);
                end
                else
                begin
                    next_st.cap_c0 = vec_parity(st.caption_fallback_char);
                    next_st.cap_c1 = vec_parity(st.caption_fallback_char);
                end
                next_st.even_fresh = 1'b0;
                next_st.even_caption_flag = 1'b1;
            end
            else
            begin
                if (st.odd_fresh)
                begin
                    next_st.cap_c0 = vec_parity(st.odd_chars[13:7]);
                    next_st.cap_c1 = vec_parity(st.odd_chars[6:0]);
                end
                else
                begin
                    next_st.cap_c0 = vec_parity(st.caption_fallback_char);
                    next_st.cap_c1 = vec_parity(st.caption_fallback_char);
                end
                next_st.odd_fresh = 1'b0;
                next_st.odd_caption_flag = 1'b1;
            end
        end

        // attribute slot
        next_st.atr_valid = hs_rise && (st.lcount == ATTR_LINE)
                            && st.attr2[POS_ATTR_EN];
        if (st.pal_mode)
        begin
            next_st.atr_word = {6'h00, st.attr2[5:3], st.attr2[2:0],
                                st.attr1[7:4], st.attr1[3:0]};
        end
        else
        begin
            next_st.atr_word = {st.attr2[5:0], st.attr1[7:4], st.attr1[3:0],
                                st.attr0[5:3], st.attr0[2:0]};
        end

        // bus handshake
        next_st.ack = req & ~st.ack;
        if (rd_take)
        begin
            unique case (address)
                OFS_AUX_PTN_0: next_st.rdata = {16'h0000, st.aux_clock_pattern_bits[15:0]};
                OFS_AUX_PTN_1: next_st.rdata = {16'h0000, st.aux_clock_pattern_bits[31:16]};
                OFS_AUX_PTN_2: next_st.rdata = {16'h0000, st.aux_clock_pattern_bits[47:32]};
                OFS_AUX_PTN_3: next_st.rdata = {16'h0000, st.aux_clock_pattern_bits[63:48]};
                OFS_HORIZ_MASK_START: next_st.rdata = {19'h0_0000, st.horiz_window_start};
                OFS_HORIZ_AUX_MASK_START: next_st.rdata = {19'h0_0000, st.horiz_aux_start};
                OFS_HORIZ_MASK_RANGE: next_st.rdata = {19'h0_0000, st.horiz_window_range};
                OFS_VERT_MASK_START: next_st.rdata = {19'h0_0000, st.vert_window_start};
                OFS_VERT_MASK_RANGE: next_st.rdata = {19'h0_0000, st.vert_window_range};
                OFS_CAPTION_CONTROL: next_st.rdata = {17'h0_0000, st.caption_fallback_char,
                                                      6'h00, st.caption_field_select};
                OFS_CAPTION_ODD: next_st.rdata = {17'h0_0000, st.odd_chars[13:7], 1'b0,
                                                  st.odd_chars[6:0]};
                OFS_CAPTION_EVEN: next_st.rdata = {17'h0_0000, st.even_chars[13:7], 1'b0,
                                                   st.even_chars[6:0]};
                OFS_ATTR_0: next_st.rdata = {24'h00_0000, st.attr0};
                OFS_ATTR_1: next_st.rdata = {24'h00_0000, st.attr1};
                OFS_ATTR_2: next_st.rdata = {24'h00_0000, st.attr2[7], 1'b0, st.attr2[5:0]};
                OFS_VIDEO_STATUS: next_st.rdata = {22'h00_0000, st.even_caption_flag,
                                                   st.odd_caption_flag, 3'h0,
                                                   st.fid_sync[1], 2'h0, st.bal_sync[1],
                                                   st.full_sync[1]};
                OFS_CLOCK_CONTROL: next_st.rdata = {16'h0000, st.internal_clock_pattern_mode,
                                                    4'h0, st.clock_mask_enable, 9'h000,
                                                    st.pal_mode};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // register writes, taken on the edge after waitrequest falls, while it is low
        if (wr_fire)
        begin
            unique case (address)
                OFS_AUX_PTN_0:
                begin
                    next_st.aux_clock_pattern_bits[15:0] = vec_merge16(
                        st.aux_clock_pattern_bits[15:0], writedata, byteenable);
                end
                OFS_AUX_PTN_1:
                begin
                    next_st.aux_clock_pattern_bits[31:16] = vec_merge16(
                        st.aux_clock_pattern_bits[31:16], writedata, byteenable);
                end
                OFS_AUX_PTN_2:
                begin
                    next_st.aux_clock_pattern_bits[47:32] = vec_merge16(
                        st.aux_clock_pattern_bits[47:32], writedata, byteenable);
                end
                OFS_AUX_PTN_3:
                begin
                    next_st.aux_clock_pattern_bits[63:48] = vec_merge16(
                        st.aux_clock_pattern_bits[63:48], writedata, byteenable);
                end
                OFS_HORIZ_MASK_START:
                begin
                    wmerged = vec_merge16({3'h0, st.horiz_window_start}, writedata, byteenable);
                    next_st.horiz_window_start = wmerged[12:0];
                end
                OFS_HORIZ_AUX_MASK_START:
                begin
                    wmerged = vec_merge16({3'h0, st.horiz_aux_start}, writedata, byteenable);
                    next_st.horiz_aux_start = wmerged[12:0];
                end
                OFS_HORIZ_MASK_RANGE:
                begin
                    wmerged = vec_merge16({3'h0, st.horiz_window_range}, writedata, byteenable);
                    next_st.horiz_window_range = wmerged[12:0];
                end
                OFS_VERT_MASK_START:
                begin
                    wmerged = vec_merge16({3'h0, st.vert_window_start}, writedata, byteenable);
                    next_st.vert_window_start = wmerged[12:0];
                end
                OFS_VERT_MASK_RANGE:
                begin
                    wmerged = vec_merge16({3'h0, st.vert_window_range}, writedata, byteenable);
                    next_st.vert_window_range = wmerged[12:0];
                end
                OFS_CAPTION_CONTROL:
                begin
                    wmerged = vec_merge16({1'b0, st.caption_fallback_char, 6'h00,
                                           st.caption_field_select}, writedata, byteenable);
                    next_st.caption_fallback_char = wmerged[14:8];
                    next_st.caption_field_select = wmerged[1:0];
                end
                OFS_CAPTION_ODD:
                begin
                    wmerged = vec_merge16({1'b0, st.odd_chars[13:7], 1'b0, st.odd_chars[6:0]},
                                          writedata, byteenable);
                    next_st.odd_chars = {wmerged[14:8], wmerged[6:0]};
                    next_st.odd_fresh = 1'b1;
                    next_st.odd_caption_flag = cap_send & ~cur_even;
                end
                OFS_CAPTION_EVEN:
                begin
                    wmerged = vec_merge16({1'b0, st.even_chars[13:7], 1'b0, st.even_chars[6:0]},
                                          writedata, byteenable);
                    next_st.even_chars = {wmerged[14:8], wmerged[6:0]};
                    next_st.even_fresh = 1'b1;
                    next_st.even_caption_flag = cap_send & cur_even;
                end
                OFS_ATTR_0:
                begin
                    if (byteenable[0])
                    begin
                        next_st.attr0 = writedata[7:0];
                    end
                end
                OFS_ATTR_1:
                begin
                    if (byteenable[0])
                    begin
                        next_st.attr1 = writedata[7:0];
                    end
                end
                OFS_ATTR_2:
                begin
                    if (byteenable[0])
                    begin
                        next_st.attr2 = {writedata[7], 1'b0, writedata[5:0]};
                    end
                end
                OFS_CLOCK_CONTROL:
                begin
                    wmerged = vec_merge16({st.internal_clock_pattern_mode, 4'h0,
                                           st.clock_mask_enable, 9'h000, st.pal_mode},
                                          writedata, byteenable);
                    next_st.internal_clock_pattern_mode = wmerged[POS_INT_MODE];
                    next_st.clock_mask_enable = wmerged[POS_MASK_EN];
                    next_st.pal_mode = wmerged[POS_PAL_MODE];
                end
                default:
                begin
                    wmerged = 16'h0000;
                end
            endcase
        end

        if (sys_rst)
        begin
            next_st = '0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign waitrequest = (read | write) & ~st.ack;
    assign readdata = st.rdata;
    assign pixel_clock_out = st.pix_out;
    assign internal_pixel_clock = st.int_clk;
    assign aux_window_active = st.aux_win;
    assign caption_valid = st.cap_valid;
    assign caption_even_field = st.cap_even;
    assign caption_first_char = st.cap_c0;
    assign caption_second_char = st.cap_c1;
    assign attribute_valid = st.atr_valid;
    assign attribute_pal = st.pal_mode;
    assign attribute_word = st.atr_word;

endmodule

`default_nettype wire

/* tb/vec_encoder_props.sv */
// vec_encoder_props: bus, caption and attribute output properties.
// assumes it is bound into vec_encoder and sees its ports by name.
`timescale 1ns/1ps
`default_nettype none
module vec_encoder_props (
    // watched ports
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic read,
    input wire logic write,
    input wire logic [6:0] address,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic caption_valid,
    input wire logic [7:0] caption_first_char,
    input wire logic [7:0] caption_second_char,
    input wire logic attribute_valid,
    input wire logic attribute_pal,
    input wire logic [19:0] attribute_word,
    input wire logic pixel_clock_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    chk_rsvd_zero: assert property (read && !waitrequest |-> readdata[31:16] == 0)
        else $error("reserved bits set");
    chk_status_rsvd: assert property (read && !waitrequest && address == 7'h3C |->
        readdata[15:10] == 0 && readdata[7:5] == 0 && readdata[3:2] == 0) else $error("status");
    chk_cap_pulse: assert property (caption_valid |=> !caption_valid)
        else $error("caption pulse long");
    chk_cap_parity: assert property (caption_valid |-> ^caption_first_char && ^caption_second_char)
        else $error("caption parity");
    chk_cap_hold: assert property (!caption_valid |-> $stable(caption_first_char))
        else $error("caption char moved");
    chk_attr_pulse: assert property (attribute_valid |=> !attribute_valid)
        else $error("attribute pulse long");
    chk_pal_top: assert property (attribute_valid && attribute_pal |-> attribute_word[19:14] == 0)
        else $error("pal word top bits");
    cover property (caption_valid);
    cover property (attribute_valid && attribute_pal);
    cover property (pixel_clock_out);
endmodule
bind vec_encoder vec_encoder_props chk (.*);
`default_nettype wire

/* tb/vec_video_src.sv */
// vec_video_src: free-running encoder clock, line and field syncs.
// assumes the block samples every one of them asynchronously.
`timescale 1ns/1ps
`default_nettype none
module vec_video_src (
    // video timing
    output logic encoder_clock,
    output logic hsync,
    output logic vsync,
    output logic field_id
);
    int h = 0;
    int l = 0;
    initial
    begin
        encoder_clock = 0;
        hsync = 0;
        vsync = 0;
        field_id = 0;
    end
    always #62.5 encoder_clock = ~encoder_clock;
    // 8 ticks a line, 24 lines a field, vsync mid-line
    always @(posedge encoder_clock)
    begin
        h <= (h == 7) ? 0 : h + 1;
        if (h == 7)
            l <= (l == 23) ? 0 : l + 1;
        hsync <= (h < 2);
        vsync <= (l == 23 && h > 3);
        if (l == 23 && h == 4)
            field_id <= ~field_id;
    end
endmodule
`default_nettype wire

/* tb/video_encoder_clock_mask_caption_attr_tb.sv */
// video_encoder_clock_mask_caption_attr_tb: register, caption, attribute, mask tests.
// assumes vec_video_src drives the video timing pins.
`timescale 1ns/1ps
`default_nettype none
module video_encoder_clock_mask_caption_attr_tb;
    logic clock = 0, sys_rst = 1, read = 0, write = 0, f, microdisplay_balance = 1;
    logic microdisplay_full = 0, waitrequest, pixel_clock_out, internal_pixel_clock;
    logic aux_window_active, caption_valid, caption_even_field, attribute_valid, attribute_pal;
    logic encoder_clock, hsync, vsync, field_id;
    logic [3:0] byteenable = 4'hF;
    logic [6:0] address = 0;
    logic [31:0] writedata = 0, readdata, q;
    logic [7:0] caption_first_char, caption_second_char;
    logic [19:0] attribute_word;
    logic [14:0] e, cd[2];
    logic [1:0] fr = 2'b11;
    logic [6:0] ofs[13] = '{0, 7'h10, 7'h14, 7'h18, 7'h1C, 7'h20, 7'h24, 7'h28, 7'h2C, 7'h30,
        7'h34, 7'h38, 7'h40};
    logic [15:0] msk[13] = '{16'hFFFF, 16'h1FFF, 16'h1FFF, 16'h1FFF, 16'h1FFF, 16'h1FFF,
        16'h7F03, 16'h7F7F, 16'h7F7F, 16'h00FF, 16'h00FF, 16'h00BF, 16'h8401};
    int fails = 0, n_checks = 0, i, n;
    always #2 clock = ~clock;
    vec_video_src src (.*);
    vec_encoder dut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d, input logic [31:0] x);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
        @(posedge clock);
        if (!w)
            chk(q, x);
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #400000;
        fails++;
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        for (i = 0; i < 15; i++) acc(0, 7'(4 * i), 0, 0);
        acc(0, 7'h44, 0, 0);
        foreach (ofs[j]) acc(1, ofs[j], '1, 0);
        foreach (ofs[j]) acc(0, ofs[j], 0, msk[j]);
        acc(1, 7'h24, 16'h5503, 0);
        acc(1, 7'h28, 16'h4142, 0);
        cd = '{15'h4142, 15'h7F7F};
        for (i = 0; i < 3; i++)
        begin
            @(posedge clock iff caption_valid);
            f = field_id;
            e = fr[f] ? cd[f] : 15'h5555;
            fr[f] = 0;
            chk(caption_even_field, f);
            chk({caption_first_char, caption_second_char}, {~^e[14:8], e[14:8], ~^e[6:0], e[6:0]});
        end
        acc(0, 7'h3C, 0, {22'h0, 2'b11, 3'b0, field_id, 4'b0010});
        acc(1, 7'h40, 0, 0);
        acc(1, 7'h30, 16'h002A, 0);
        acc(1, 7'h34, 16'h00C3, 0);
        acc(1, 7'h38, 16'h0095, 0);
        @(posedge clock iff attribute_valid);
        chk(attribute_word, {6'h15, 4'hC, 4'h3, 3'h5, 3'h2});
        acc(1, 7'h40, 16'h0001, 0);
        acc(1, 7'h38, 16'h00A3, 0);
        @(posedge clock iff attribute_valid);
        chk({attribute_pal, attribute_word}, {1'b1, 6'h0, 3'h4, 3'h3, 4'hC, 4'h3});
        acc(1, 7'h38, 16'h0023, 0);
        acc(1, 7'h20, 0, 0);
        acc(1, 7'h40, 16'h0401, 0);
        n = 0;
        repeat (7000) @(posedge clock) n += attribute_valid + pixel_clock_out + aux_window_active;
        chk(n, 0);
        acc(1, 7'h40, 16'h0001, 0);
        repeat (300) @(posedge clock) n += pixel_clock_out;
        chk(n > 0, 1);
        acc(1, 7'h14, 0, 0);
        acc(1, 7'h40, 16'h8000, 0);
        n = 0;
        repeat (300) @(posedge clock) n += internal_pixel_clock;
        chk(n > 0, 1);
        acc(1, 7'h00, 0, 0);
        n = 0;
        repeat (300) @(posedge clock) n += internal_pixel_clock;
        chk(n, 0);
        give_verdict;
    end
endmodule
`default_nettype wire
